//--- rtl/tlvic_ctrl.sv
// Two-level vectored interrupt controller: flags, enables, arbitration, nesting
`timescale 1ns/1ps
`include "tlvic_defines.svh"
module tlvic_ctrl #(
  parameter int unsigned PIN_COUNT = 13
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  input  wire logic [PIN_COUNT-1:0]   ext_pin,
  input  wire logic                   timer0_ovf,
  input  wire logic                   timer1_ovf,
  input  wire logic                   timer2_ovf,
  input  wire logic                   uart_rx_done,
  input  wire logic                   uart_tx_done,
  input  wire logic                   conversion_start,
  input  wire logic                   conversion_done,
  input  wire logic                   serial_frame_done,
  input  wire logic                   pwm_overflow,
  input  wire logic                   base_timer_tick,
  input  wire logic                   touch_overflow,
  input  wire logic                   irq_ack,
  input  wire logic                   irq_reti,
  output tlvic_pkg::tlvic_grant_t     irq_grant,
  output logic                        stop_wake
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  localparam int unsigned L0 = `TLVIC_LINE0_PINS;
  localparam int unsigned L1 = `TLVIC_LINE1_PINS;
  localparam int unsigned L2 = `TLVIC_LINE2_PINS;

  if (PIN_COUNT != L0 + L1 + L2) begin : g_pin_check
    $error("PIN_COUNT must equal the pins of the three external lines");
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [7:0]            enable_q;
  logic [4:0]            enable_b_q;
  logic [6:0]            prio_q;
  logic [4:0]            prio_b_q;
  logic [PIN_COUNT-1:0]  rise_q;
  logic [PIN_COUNT-1:0]  fall_q;
  logic                  wr_en;
  logic                  wr_en_b;
  logic                  wr_prio;
  logic                  wr_prio_b;
  logic                  wr_flag;
  logic                  wr_flag_b;
  logic                  wr_conv;

  assign wr_en     = reg_wr && (reg_addr == `TLVIC_ADDR_ENABLE);
  assign wr_en_b   = reg_wr && (reg_addr == `TLVIC_ADDR_ENABLE_B);
  assign wr_prio   = reg_wr && (reg_addr == `TLVIC_ADDR_PRIO);
  assign wr_prio_b = reg_wr && (reg_addr == `TLVIC_ADDR_PRIO_B);
  assign wr_flag   = reg_wr && (reg_addr == `TLVIC_ADDR_FLAG);
  assign wr_flag_b = reg_wr && (reg_addr == `TLVIC_ADDR_FLAG_B);
  assign wr_conv   = reg_wr && (reg_addr == `TLVIC_ADDR_CONV_CTRL);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q   <= `TLVIC_REG_RESET;
      enable_b_q <= 5'(`TLVIC_REG_RESET);
    end else begin
      if (wr_en) begin
        enable_q <= reg_wdata;
      end
      if (wr_en_b) begin
        enable_b_q <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prio_q   <= 7'(`TLVIC_REG_RESET);
      prio_b_q <= 5'(`TLVIC_REG_RESET);
    end else begin
      if (wr_prio) begin
        prio_q <= reg_wdata[6:0];
      end
      if (wr_prio_b) begin
        prio_b_q <= reg_wdata[4:0];
      end
    end
  end

  // Pin select registers: low byte holds pins 0-7, second byte the rest
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      if (reg_wr && reg_addr == `TLVIC_ADDR_RISE) begin
        rise_q[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `TLVIC_ADDR_RISE_B) begin
        rise_q[PIN_COUNT-1:8] <= reg_wdata[PIN_COUNT-9:0];
      end
      if (reg_wr && reg_addr == `TLVIC_ADDR_FALL) begin
        fall_q[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `TLVIC_ADDR_FALL_B) begin
        fall_q[PIN_COUNT-1:8] <= reg_wdata[PIN_COUNT-9:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // External pins and lines
  // --------------------------------------------------------------------------
  logic [PIN_COUNT-1:0] pin_edge;
  logic                 ext_line0_evt;
  logic                 ext_line1_evt;
  logic                 ext_line2_evt;

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    tlvic_pin_edge u_pin_edge (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .pin_in   (ext_pin[p]),
      .rise_sel (rise_q[p]),
      .fall_sel (fall_q[p]),
      .edge_q   (pin_edge[p])
    );
  end

  assign ext_line0_evt = |pin_edge[L0-1:0];
  assign ext_line1_evt = |pin_edge[L0+L1-1:L0];
  assign ext_line2_evt = |pin_edge[PIN_COUNT-1:L0+L1];

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  tlvic_pkg::tlvic_grant_t      grant_q;
  tlvic_pkg::tlvic_grant_t      grant_d;
  logic [`TLVIC_NUM_FLAGS-1:0]  flag_set;
  logic [`TLVIC_NUM_FLAGS-1:0]  flag_hw_clr;
  logic [`TLVIC_NUM_FLAGS-1:0]  flag_sw_clr;
  logic [`TLVIC_NUM_FLAGS-1:0]  flag;
  logic [`TLVIC_NUM_SRC-1:0]    auto_clr;
  logic                         take;

  assign take     = irq_ack && grant_q.valid;
  assign auto_clr = `TLVIC_AUTO_CLR_MASK;

  // Flag index equals polling rank minus one; the UART transmit flag sits last
  assign flag_set = {uart_tx_done, touch_overflow, ext_line2_evt, base_timer_tick,
                     pwm_overflow, serial_frame_done, conversion_done, timer2_ovf,
                     uart_rx_done, timer1_ovf, ext_line1_evt, timer0_ovf,
                     ext_line0_evt};

  always_comb begin
    flag_hw_clr = '0;
    for (int i = 0; i < `TLVIC_NUM_SRC; i++) begin
      flag_hw_clr[i] = take && (grant_q.src == 4'(i)) && auto_clr[i];
    end
    flag_hw_clr[`TLVIC_SRC_ADC] = conversion_start;
  end

  // Writing 0 to a flag bit clears it; writing 1 leaves it alone
  always_comb begin
    flag_sw_clr = '0;
    if (wr_flag) begin
      flag_sw_clr[7:0] = ~reg_wdata;
    end
    if (wr_flag_b) begin
      flag_sw_clr[9:8]                 = ~reg_wdata[1:0];
      flag_sw_clr[11]                  = ~reg_wdata[3];
      flag_sw_clr[`TLVIC_FLAG_UART_TX] = ~reg_wdata[4];
    end
    if (wr_conv && !reg_wdata[`TLVIC_CONV_DONE_BIT]) begin
      flag_sw_clr[`TLVIC_SRC_ADC] = 1'b1;
    end
  end

  for (genvar f = 0; f < `TLVIC_NUM_FLAGS; f++) begin : g_flag
    tlvic_flag u_flag (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set_evt (flag_set[f]),
      .hw_clr  (flag_hw_clr[f]),
      .sw_clr  (flag_sw_clr[f]),
      .flag_q  (flag[f])
    );
  end

  // --------------------------------------------------------------------------
  // Request gating and arbitration
  // --------------------------------------------------------------------------
  tlvic_pkg::tlvic_state_t     state_q;
  logic [`TLVIC_NUM_SRC-1:0]   src_flag;
  logic [`TLVIC_NUM_SRC-1:0]   src_en;
  logic [`TLVIC_NUM_SRC-1:0]   src_prio;
  logic [`TLVIC_NUM_SRC-1:0]   pend;
  logic [`TLVIC_NUM_SRC-1:0]   hi_pend;
  logic [`TLVIC_NUM_SRC-1:0]   lo_pend;
  logic                        allow_hi;
  logic                        allow_lo;
  logic [3:0]                  hi_idx;
  logic [3:0]                  lo_idx;

  always_comb begin
    src_flag                  = flag[`TLVIC_NUM_SRC-1:0];
    src_flag[`TLVIC_SRC_UART] = flag[`TLVIC_SRC_UART] | flag[`TLVIC_FLAG_UART_TX];
  end

  assign src_en   = {enable_b_q, enable_q[6:0]};
  assign src_prio = {prio_b_q, prio_q};
  assign pend     = src_flag & src_en & {`TLVIC_NUM_SRC{enable_q[`TLVIC_GLOBAL_EN_BIT]}};
  assign hi_pend  = pend & src_prio;
  assign lo_pend  = pend & ~src_prio;

  // Lowest index is the lowest vector, so scan downward and keep the last hit
  always_comb begin
    hi_idx = '0;
    lo_idx = '0;
    for (int i = `TLVIC_NUM_SRC - 1; i >= 0; i--) begin
      if (hi_pend[i]) begin
        hi_idx = 4'(i);
      end
      if (lo_pend[i]) begin
        lo_idx = 4'(i);
      end
    end
  end

  // Which level may still be accepted depends on what is already in service
  always_comb begin
    unique case (state_q)
      tlvic_pkg::TLVIC_IDLE: begin
        allow_hi = 1'b1;
        allow_lo = 1'b1;
      end
      tlvic_pkg::TLVIC_LOW: begin
        allow_hi = 1'b1;
        allow_lo = 1'b0;
      end
      tlvic_pkg::TLVIC_HIGH, tlvic_pkg::TLVIC_LOW_HIGH: begin
        allow_hi = 1'b0;
        allow_lo = 1'b0;
      end
    endcase
  end

  always_comb begin
    grant_d = '0;
    if (allow_hi && |hi_pend) begin
      grant_d.valid = 1'b1;
      grant_d.level = 1'b1;
      grant_d.src   = hi_idx;
    end else if (allow_lo && |lo_pend) begin
      grant_d.valid = 1'b1;
      grant_d.level = 1'b0;
      grant_d.src   = lo_idx;
    end
    grant_d.vector = `TLVIC_VEC_BASE + {grant_d.src, 3'b000};
    // Drop the offer for one cycle after acceptance so a stale flag is not re-offered
    if (take) begin
      grant_d.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_d;
    end
  end

  assign irq_grant = grant_q;

  // --------------------------------------------------------------------------
  // Service nesting
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= tlvic_pkg::TLVIC_IDLE;
    end else if (take) begin
      unique case (state_q)
        tlvic_pkg::TLVIC_IDLE: begin
          state_q <= grant_q.level ? tlvic_pkg::TLVIC_HIGH : tlvic_pkg::TLVIC_LOW;
        end
        tlvic_pkg::TLVIC_LOW: begin
          state_q <= tlvic_pkg::TLVIC_LOW_HIGH;
        end
        tlvic_pkg::TLVIC_HIGH, tlvic_pkg::TLVIC_LOW_HIGH: begin
          state_q <= state_q;
        end
      endcase
    end else if (irq_reti) begin
      unique case (state_q)
        tlvic_pkg::TLVIC_LOW_HIGH: begin
          state_q <= tlvic_pkg::TLVIC_LOW;
        end
        tlvic_pkg::TLVIC_HIGH, tlvic_pkg::TLVIC_LOW: begin
          state_q <= tlvic_pkg::TLVIC_IDLE;
        end
        tlvic_pkg::TLVIC_IDLE: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // STOP wake
  // --------------------------------------------------------------------------
  // Wake ignores the global enable so a sleeping core can still be roused
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= |(src_flag & src_en & `TLVIC_WAKE_MASK);
    end
  end

  // --------------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      `TLVIC_ADDR_ENABLE:    rdata_d = enable_q;
      `TLVIC_ADDR_ENABLE_B:  rdata_d = {3'b000, enable_b_q};
      `TLVIC_ADDR_PRIO:      rdata_d = {1'b0, prio_q};
      `TLVIC_ADDR_PRIO_B:    rdata_d = {3'b000, prio_b_q};
      `TLVIC_ADDR_FLAG:      rdata_d = flag[7:0];
      `TLVIC_ADDR_FLAG_B:    rdata_d = {3'b000, flag[12], flag[11], 1'b0, flag[9:8]};
      `TLVIC_ADDR_RISE:      rdata_d = rise_q[7:0];
      `TLVIC_ADDR_RISE_B:    rdata_d = 8'(rise_q[PIN_COUNT-1:8]);
      `TLVIC_ADDR_FALL:      rdata_d = fall_q[7:0];
      `TLVIC_ADDR_FALL_B:    rdata_d = 8'(fall_q[PIN_COUNT-1:8]);
      `TLVIC_ADDR_STATUS:    rdata_d = {grant_q.src, 1'b0, grant_q.valid, state_q};
      `TLVIC_ADDR_CONV_CTRL: rdata_d = 8'(flag[`TLVIC_SRC_ADC]) << `TLVIC_CONV_DONE_BIT;
      default:               rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

endmodule // tlvic_ctrl

//--- rtl/tlvic_defines.svh
// Register map, field positions, masks and vector constants of the interrupt controller
`ifndef TLVIC_DEFINES_SVH
`define TLVIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TLVIC_ADDR_ENABLE      8'h00
`define TLVIC_ADDR_ENABLE_B    8'h01
`define TLVIC_ADDR_PRIO        8'h02
`define TLVIC_ADDR_PRIO_B      8'h03
`define TLVIC_ADDR_FLAG        8'h04
`define TLVIC_ADDR_FLAG_B      8'h05
`define TLVIC_ADDR_RISE        8'h06
`define TLVIC_ADDR_RISE_B      8'h07
`define TLVIC_ADDR_FALL        8'h08
`define TLVIC_ADDR_FALL_B      8'h09
`define TLVIC_ADDR_STATUS      8'h0A
`define TLVIC_ADDR_CONV_CTRL   8'h0B

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TLVIC_GLOBAL_EN_BIT    7
`define TLVIC_CONV_DONE_BIT    5
`define TLVIC_REG_RESET        8'h00
`define TLVIC_FLAG_B_HIDDEN    2

// ----------------------------------------------------------------------------
// Sources, pins and vectors
// ----------------------------------------------------------------------------
`define TLVIC_NUM_SRC          12
`define TLVIC_NUM_FLAGS        13
`define TLVIC_SRC_UART         4
`define TLVIC_SRC_ADC          6
`define TLVIC_SRC_EXT2         10
`define TLVIC_FLAG_UART_TX     12
`define TLVIC_LINE0_PINS       3
`define TLVIC_LINE1_PINS       4
`define TLVIC_LINE2_PINS       6
`define TLVIC_VEC_BASE         16'h0003
`define TLVIC_VEC_STEP         16'h0008
`define TLVIC_AUTO_CLR_MASK    12'hF0F
`define TLVIC_WAKE_MASK        12'hE05

`endif

//--- rtl/tlvic_flag.sv
// One interrupt flag: hardware set, hardware or software clear, set wins
`timescale 1ns/1ps
module tlvic_flag (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic set_evt,
  input  wire logic hw_clr,
  input  wire logic sw_clr,
  output logic      flag_q
);

  // A set in the same cycle as a clear is kept so no event is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (hw_clr || sw_clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // tlvic_flag

//--- rtl/tlvic_pin_edge.sv
// Synchroniser and edge detector for one external interrupt pin
`timescale 1ns/1ps
module tlvic_pin_edge (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  input  wire logic rise_sel,
  input  wire logic fall_sel,
  output logic      edge_q
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once stages two and three agree, so a one-cycle runt is dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else if ((sync2_q == sync3_q) && (sync3_q != level_q)) begin
      level_q <= sync3_q;
      edge_q  <= (sync3_q & rise_sel) | (~sync3_q & fall_sel);
    end else begin
      edge_q <= 1'b0;
    end
  end

endmodule // tlvic_pin_edge

//--- rtl/tlvic_pkg.sv
// Types shared by the interrupt controller files
package tlvic_pkg;

  // Service nesting: Gray codes along idle -> low -> low+high and idle -> high
  typedef enum logic [1:0] {
    TLVIC_IDLE     = 2'b00,
    TLVIC_LOW      = 2'b01,
    TLVIC_LOW_HIGH = 2'b11,
    TLVIC_HIGH     = 2'b10
  } tlvic_state_t;

  // Request offered to the CPU
  typedef struct packed {
    logic        valid;
    logic        level;
    logic [3:0]  src;
    logic [15:0] vector;
  } tlvic_grant_t;

endpackage : tlvic_pkg

//--- testbench/tlvic_cpu_model.sv
// Behavioural core that takes offered interrupts and returns on command
`timescale 1ns/1ps
module tlvic_cpu_model (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    accept_en,
  input  wire logic                    ret_cmd,
  input  wire tlvic_pkg::tlvic_grant_t irq_grant,
  output logic                         irq_ack,
  output logic                         irq_reti
);
  // One-cycle ack so that a second take never rides on a stale ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
    end else begin
      irq_ack  <= accept_en && irq_grant.valid && !irq_ack;
      irq_reti <= ret_cmd;
    end
  end
endmodule // tlvic_cpu_model

//--- testbench/tlvic_ctrl_sva.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
module tlvic_ctrl_sva #(
  parameter int unsigned PIN_COUNT = 13
) (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic [7:0]              reg_addr,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic [PIN_COUNT-1:0]    ext_pin,
  input wire logic                    base_timer_tick,
  input wire logic                    touch_overflow,
  input wire logic                    irq_ack,
  input wire logic                    irq_reti,
  input wire tlvic_pkg::tlvic_grant_t irq_grant,
  input wire logic                    stop_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------
  // Shadow state
  // ------------
  logic        hi_q, lo_q;
  logic [3:0]  age_q;
  wire  [15:0] vec_w = 16'h0003 + {9'h000, irq_grant.src, 3'h0};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else if (irq_ack && irq_grant.valid) begin
      if (irq_grant.level) hi_q <= 1'b1;
      else lo_q <= 1'b1;
    end else if (irq_reti) begin
      if (hi_q) hi_q <= 1'b0;
      else lo_q <= 1'b0;
    end
  end
  // A register write may enable a flag already waiting, so it also counts as a cause
  always_ff @(posedge clk) begin
    if (sys_rst || reg_wr || base_timer_tick || touch_overflow || ext_pin != $past(ext_pin))
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end
  // ----------
  // Properties
  // ----------
  sequence s_take;
    irq_ack && irq_grant.valid;
  endsequence
  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  AST_VECTOR: assert property (irq_grant.valid |-> irq_grant.vector == vec_w)
    else $error("grant vector does not match its source");
  AST_SRC_RANGE: assert property (irq_grant.valid |-> irq_grant.src <= 4'hB)
    else $error("grant names a source beyond twelve");
  AST_TAKE_DROP: assert property (s_take |=> !irq_grant.valid)
    else $error("grant still offered after it was taken");
  AST_HIGH_BLOCKS: assert property (hi_q |-> !irq_grant.valid)
    else $error("request offered during a high routine");
  AST_LOW_NEEDS_HIGH: assert property (lo_q && irq_grant.valid |-> irq_grant.level)
    else $error("low request offered during a low routine");
  AST_WAKE_CAUSE: assert property ($rose(stop_wake) |-> age_q < 4'hC)
    else $error("wake raised without a wake-capable event");
  AST_LINE2_HIDDEN: assert property (s_read(8'h05) |=> !reg_rdata[2])
    else $error("hidden line 2 flag read as set");
  AST_STATE: assert property (s_read(8'h0A) |=> reg_rdata[1:0] == {$past(hi_q), $past(lo_q)})
    else $error("nesting state differs from take and return history");
endmodule // tlvic_ctrl_sva
bind tlvic_ctrl tlvic_ctrl_sva #(.PIN_COUNT(PIN_COUNT)) tlvic_ctrl_sva_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_pin(ext_pin), .base_timer_tick(base_timer_tick),
  .touch_overflow(touch_overflow), .irq_ack(irq_ack), .irq_reti(irq_reti),
  .irq_grant(irq_grant), .stop_wake(stop_wake));

//--- testbench/two_level_vectored_irq_ctrl_tb.sv
// Self-checking bench: register port, priority, nesting, pins and wake
`timescale 1ns/1ps
module two_level_vectored_irq_ctrl_tb;
  logic                    clk, sys_rst, reg_wr, reg_rd, accept_en, ret_cmd, rd_s;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata;
  logic [12:0]             ext_pin, rm, fm;
  logic [10:0]             ev;
  logic                    irq_ack, irq_reti, stop_wake;
  logic [4:0]              g;
  tlvic_pkg::tlvic_grant_t irq_grant;
  logic [7:0]              rq_e[$], rq_m[$];
  logic [4:0]              gq[$];
  int                      errors, n_tests, seed, p0, p1, p2;
  int                      ord[8] = '{1, 3, 4, 5, 6, 7, 8, 9};
  // ------------
  // Design parts
  // ------------
  tlvic_ctrl #(.PIN_COUNT(13)) tlvic_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .timer0_ovf(ev[0]), .timer1_ovf(ev[1]), .timer2_ovf(ev[2]), .uart_rx_done(ev[3]),
    .uart_tx_done(ev[4]), .conversion_start(ev[5]), .conversion_done(ev[6]),
    .serial_frame_done(ev[7]), .pwm_overflow(ev[8]), .base_timer_tick(ev[9]),
    .touch_overflow(ev[10]), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .irq_grant(irq_grant), .stop_wake(stop_wake));
  tlvic_cpu_model tlvic_cpu_model_i (.clk(clk), .sys_rst(sys_rst), .accept_en(accept_en),
    .ret_cmd(ret_cmd), .irq_grant(irq_grant), .irq_ack(irq_ack), .irq_reti(irq_reti));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // -----------------
  // Checks and verdict
  // -----------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpg(input tlvic_pkg::tlvic_grant_t got, input tlvic_pkg::tlvic_grant_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: grant %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Results are judged against the oldest note left by the driver
  always @(posedge clk) begin
    if (rd_s) begin
      cmp8(reg_rdata & rq_m[0], rq_e[0]);
      void'(rq_e.pop_front());
      void'(rq_m.pop_front());
    end
    if (irq_ack && irq_grant.valid) begin
      if (gq.size() == 0) g = 5'h1F;
      else g = gq.pop_front();
      cmpg(irq_grant, {1'b1, g, 16'h0003 + {9'h000, g[3:0], 3'h0}});
    end
    rd_s <= reg_rd;
  end
  initial begin
    #150000;
    errors++;
    report_and_stop();
  end
  // -------
  // Drivers
  // -------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rq_e.push_back(e);
    rq_m.push_back(m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 11'h000;
  endtask
  task automatic flip(input int p);
    @(posedge clk);
    ext_pin[p] <= ~ext_pin[p];
  endtask
  task automatic quiet();
    repeat (8) @(posedge clk);
    cmp8({7'h00, irq_grant.valid}, 8'h00);
  endtask
  // Pins of all three external lines need the sync delay, hence the 60-cycle bound
  task automatic take(input logic [3:0] s, input logic l);
    logic [7:0] m;
    int         i;
    m = 8'h01 << (s[3] ? s - 4'h8 : s);
    gq.push_back({l, s});
    for (i = 0; i < 60 && gq.size() > 0; i++) @(posedge clk);
    cmp8({7'h00, gq.size() == 0}, 8'h01);
    rd(s[3] ? 8'h05 : 8'h04, (s inside {[4:7]}) ? m : 8'h00, m);
    if (s == 4'h4) rd(8'h05, 8'h10, 8'h10);
  endtask
  task automatic done(input logic [3:0] s);
    if (s inside {[4:7]}) wr(8'h04, ~(8'h01 << s));
    if (s == 4'h4) wr(8'h05, 8'hEF);
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
  endtask
  initial begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    accept_en = 1'b0;
    ret_cmd   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    ext_pin   = 13'h0000;
    ev        = 11'h000;
    errors    = 0;
    n_tests   = 0;
    seed      = 80141;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 13; a++) rd(a == 12 ? 8'h20 : 8'(a), 8'h00, 8'hFF);
    wr(8'h00, 8'h02);
    pulse(11'h001);
    quiet();
    rd(8'h04, 8'h02, 8'h02);
    accept_en <= 1'b1;
    wr(8'h00, 8'h82);
    take(4'h1, 1'b0);
    done(4'h1);
    // All internal sources at once, external lines left quiet, touch raised to high
    accept_en <= 1'b0;
    wr(8'h00, 8'hFF);
    wr(8'h01, 8'h1F);
    wr(8'h03, 8'h10);
    pulse(11'h7DF);
    accept_en <= 1'b1;
    take(4'hB, 1'b1);
    done(4'hB);
    foreach (ord[k]) begin
      take(4'(ord[k]), 1'b0);
      done(4'(ord[k]));
    end
    // Preemption of a low routine
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h20);
    pulse(11'h001);
    take(4'h1, 1'b0);
    pulse(11'h002);
    quiet();
    pulse(11'h004);
    take(4'h5, 1'b1);
    done(4'h5);
    done(4'h1);
    take(4'h3, 1'b0);
    done(4'h3);
    // One random pin on each external line
    p0 = {$random(seed)} % 3;
    p1 = 3 + {$random(seed)} % 4;
    p2 = 7 + {$random(seed)} % 6;
    rm = (13'h0001 << p0) | (13'h0001 << p2);
    fm = (13'h0001 << p1) | (13'h0001 << p2);
    wr(8'h02, 8'h00);
    wr(8'h06, rm[7:0]);
    wr(8'h07, {3'h0, rm[12:8]});
    wr(8'h08, fm[7:0]);
    wr(8'h09, {3'h0, fm[12:8]});
    wr(8'h00, 8'h85);
    wr(8'h01, 8'h08);
    flip(p0);
    take(4'h0, 1'b0);
    done(4'h0);
    flip(p1);
    quiet();
    flip(p1);
    take(4'h2, 1'b0);
    done(4'h2);
    flip(p2);
    take(4'hA, 1'b0);
    done(4'hA);
    flip(p0);
    quiet();
    flip(p2);
    take(4'hA, 1'b0);
    done(4'hA);
    // Wake sources and conversion flag
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h04);
    pulse(11'h040);
    quiet();
    cmp8({7'h00, stop_wake}, 8'h00);
    rd(8'h0B, 8'h20, 8'h20);
    pulse(11'h020);
    rd(8'h0B, 8'h00, 8'h20);
    pulse(11'h200);
    repeat (8) @(posedge clk);
    cmp8({7'h00, stop_wake}, 8'h01);
    report_and_stop();
  end
endmodule // two_level_vectored_irq_ctrl_tb
